// File: rrsb_alu.sv
// Purpose: sequencer for rotate-right and subtract-with-borrow on a memory byte
// Assumes: data memory answers one cycle after a registered read strobe
// Notes:   read, execute and write-back finish within one instruction
`timescale 1ns/1ps
`include "rrsb_cfg.svh"

// Overview of operation
// RL1: rotate memory right into working, flags kept
// RL2: rotate memory right through carry in place
// RL3: rotate through carry into working, memory kept
// RL4: working minus memory minus inverted carry
// RL5: carry cleared if negative, else set
// RL6: borrow subtraction result written back to memory
// RL7: subtraction updates all six status flags
// RL8: byte operands, read-modify-write within instruction
module rrsb_alu
	import rrsb_pkg::*;
(
	// clock and reset
	input  wire logic         mclk_in,
	input  wire logic         rst_in,
	// instruction request
	input  wire logic         start_in,
	input  wire rrsb_op_t     op_in,
	input  wire rrsb_addr_t   addr_in,
	// working register and flag preload
	input  wire logic         load_in,
	input  wire rrsb_byte_t   load_working_in,
	input  wire rrsb_flags_t  load_flags_in,
	// data memory
	output rrsb_addr_t        mem_addr_out,
	output logic              mem_rd_out,
	output logic              mem_wr_out,
	output rrsb_byte_t        mem_wdata_out,
	input  wire rrsb_byte_t   mem_rdata_in,
	// state
	output rrsb_byte_t        working_out,
	output rrsb_flags_t       flags_out,
	output logic              busy_out,
	output logic              done_out
);

	typedef enum logic [1:0] {
		RRSB_ST_IDLE,
		RRSB_ST_READ,
		RRSB_ST_EXEC
	} rrsb_state_t;

	rrsb_state_t   state_reg;
	rrsb_op_t      op_reg;
	rrsb_byte_t    working_reg;
	rrsb_flags_t   flags_reg;
	rrsb_addr_t    addr_reg;
	logic          rd_reg;
	logic          wr_reg;
	rrsb_byte_t    wdata_reg;
	logic          done_reg;
	logic          busy_reg;
	rrsb_result_t  res_next;
	logic          exec_now;

	assign exec_now = (state_reg == RRSB_ST_EXEC);

	// ----------------------------------------
	// execute
	// ----------------------------------------
	rrsb_exec u_exec (
		.op_in      (op_reg),
		.working_in (working_reg),
		.mem_in     (mem_rdata_in),
		.flags_in   (flags_reg),
		.res_out    (res_next)
	);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_reg <= RRSB_ST_IDLE;
		end else begin
			case (state_reg)
				RRSB_ST_IDLE: begin
					if (start_in) begin
						state_reg <= RRSB_ST_READ;
					end
				end
				RRSB_ST_READ: begin
					state_reg <= RRSB_ST_EXEC;
				end
				RRSB_ST_EXEC: begin
					state_reg <= RRSB_ST_IDLE; // RL8
				end
				default: begin
					state_reg <= RRSB_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			op_reg   <= RRSB_OP_RR_TO_WORKING;
			addr_reg <= '0;
		end else if (state_reg == RRSB_ST_IDLE && start_in) begin
			op_reg   <= op_in;
			addr_reg <= addr_in; // RL8
		end
	end

	// ----------------------------------------
	// memory strobes
	// ----------------------------------------
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rd_reg <= 1'b0;
		end else begin
			rd_reg <= (state_reg == RRSB_ST_IDLE) && start_in;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			wr_reg    <= 1'b0;
			wdata_reg <= '0;
		end else begin
			wr_reg <= exec_now && res_next.wr_mem; // RL2 RL6
			if (exec_now && res_next.wr_mem) begin
				wdata_reg <= res_next.mem; // RL8
			end
		end
	end

	// ----------------------------------------
	// working register and flags
	// ----------------------------------------
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			working_reg <= '0;
		end else if (exec_now && res_next.wr_working) begin
			working_reg <= res_next.working; // RL1 RL3 RL4
		end else if (state_reg == RRSB_ST_IDLE && load_in) begin
			working_reg <= load_working_in;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			flags_reg <= '0;
		end else if (exec_now) begin
			flags_reg <= res_next.flags; // RL5 RL7
		end else if (state_reg == RRSB_ST_IDLE && load_in) begin
			flags_reg <= load_flags_in;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= exec_now;
		end
	end

	// busy flag registered so the output comes from a flip-flop
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			busy_reg <= 1'b0;
		end else if (state_reg == RRSB_ST_IDLE && start_in) begin
			busy_reg <= 1'b1;
		end else if (exec_now) begin
			busy_reg <= 1'b0; // RL8
		end
	end

	assign mem_addr_out  = addr_reg;
	assign mem_rd_out    = rd_reg;
	assign mem_wr_out    = wr_reg;
	assign mem_wdata_out = wdata_reg;
	assign working_out   = working_reg;
	assign flags_out     = flags_reg;
	assign busy_out      = busy_reg;
	assign done_out      = done_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	rrsb_byte_t chk_rot;
	rrsb_byte_t chk_rotc;
	logic [`RRSB_DATA_W:0] chk_diff;
	assign chk_rot  = {mem_rdata_in[`RRSB_LSB], mem_rdata_in[`RRSB_MSB:`RRSB_ROT_LO]};
	assign chk_rotc = {flags_reg.carry, mem_rdata_in[`RRSB_MSB:`RRSB_ROT_LO]};
	assign chk_diff = {1'b0, working_reg} - {1'b0, mem_rdata_in}
		- {{`RRSB_DATA_W{1'b0}}, ~flags_reg.carry};

	rot_working_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL1
		exec_now && op_reg == RRSB_OP_RR_TO_WORKING |=>
		working_reg == $past(chk_rot) && flags_reg == $past(flags_reg) && !mem_wr_out)
		else $error("rotate to working wrong");
	rot_carry_mem_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL2
		exec_now && op_reg == RRSB_OP_RR_THROUGH_CARRY |=>
		mem_wr_out && mem_wdata_out == $past(chk_rotc)
		&& flags_reg.carry == $past(mem_rdata_in[`RRSB_LSB])
		&& working_reg == $past(working_reg))
		else $error("rotate through carry in place wrong");
	rot_carry_work_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL3
		exec_now && op_reg == RRSB_OP_RR_THROUGH_CARRY_TO_WORKING |=>
		working_reg == $past(chk_rotc) && !mem_wr_out
		&& flags_reg.carry == $past(mem_rdata_in[`RRSB_LSB]))
		else $error("rotate through carry to working wrong");
	sub_working_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL4
		exec_now && op_reg == RRSB_OP_SUB_BORROW |=>
		working_reg == $past(chk_diff[`RRSB_MSB:0]) && !mem_wr_out)
		else $error("subtract to working wrong");
	sub_carry_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL5
		exec_now && (op_reg == RRSB_OP_SUB_BORROW || op_reg == RRSB_OP_SUB_BORROW_TO_MEMORY)
		|=> flags_reg.carry == !$past(chk_diff[`RRSB_DATA_W]))
		else $error("subtract carry wrong");
	sub_memory_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL6
		exec_now && op_reg == RRSB_OP_SUB_BORROW_TO_MEMORY |=>
		mem_wr_out && mem_wdata_out == $past(chk_diff[`RRSB_MSB:0])
		&& working_reg == $past(working_reg))
		else $error("subtract to memory wrong");
	sub_zero_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL7
		exec_now && (op_reg == RRSB_OP_SUB_BORROW || op_reg == RRSB_OP_SUB_BORROW_TO_MEMORY)
		|=> flags_reg.zero == ($past(chk_diff[`RRSB_MSB:0]) == `RRSB_ZERO_B))
		else $error("subtract zero flag wrong");
	instr_span_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL8
		!busy_out && start_in |=> mem_rd_out ##1 busy_out ##1 done_out && !busy_out)
		else $error("instruction span wrong");
	wr_addr_a: assert property (@(posedge mclk_in) disable iff (rst_in) // RL8
		mem_wr_out |-> mem_addr_out == $past(mem_addr_out, 2) && done_out)
		else $error("write-back address moved");

endmodule : rrsb_alu

// File: rrsb_cfg.svh
// Purpose: constants for the rotate-right / subtract-with-borrow datapath
// Assumes: 8-bit data bytes, extended data-memory address
// Notes:   widths and bit positions used by package and modules
`ifndef RRSB_CFG_SVH
`define RRSB_CFG_SVH

`define RRSB_DATA_W   8
`define RRSB_MSB      7
`define RRSB_LSB      0
`define RRSB_ROT_LO   1
`define RRSB_NIB_W    4
`define RRSB_NIB_MSB  3
`define RRSB_ADDR_W   16
`define RRSB_ZERO_B   8'h00

`endif

// File: rrsb_exec.sv
// Purpose: combinational result of one instruction
// Assumes: operands valid in the execute cycle
// Notes:   no state; the top module registers everything
`timescale 1ns/1ps
`include "rrsb_cfg.svh"

module rrsb_exec
	import rrsb_pkg::*;
(
	// operation and operands
	input  wire rrsb_op_t     op_in,
	input  wire rrsb_byte_t   working_in,
	input  wire rrsb_byte_t   mem_in,
	input  wire rrsb_flags_t  flags_in,
	// result
	output rrsb_result_t      res_out
);

	logic [`RRSB_DATA_W:0]   diff;
	logic [`RRSB_NIB_W:0]    nib;
	rrsb_byte_t              rot;

	always_comb begin
		// borrow-inclusive difference, borrow in is the inverted carry
		diff = {1'b0, working_in} - {1'b0, mem_in}
			- {{`RRSB_DATA_W{1'b0}}, ~flags_in.carry};
		nib  = {1'b0, working_in[`RRSB_NIB_MSB:0]} - {1'b0, mem_in[`RRSB_NIB_MSB:0]}
			- {{`RRSB_NIB_W{1'b0}}, ~flags_in.carry};
		rot  = {mem_in[`RRSB_LSB], mem_in[`RRSB_MSB:`RRSB_ROT_LO]};
		res_out            = '0;
		res_out.working    = working_in;
		res_out.mem        = mem_in;
		res_out.flags      = flags_in;
		case (op_in)
			RRSB_OP_RR_TO_WORKING: begin
				res_out.working    = rot; // RL1
				res_out.wr_working = 1'b1;
			end
			RRSB_OP_RR_THROUGH_CARRY: begin
				res_out.mem         = {flags_in.carry, mem_in[`RRSB_MSB:`RRSB_ROT_LO]}; // RL2
				res_out.flags.carry = mem_in[`RRSB_LSB]; // RL2
				res_out.wr_mem      = 1'b1;
			end
			RRSB_OP_RR_THROUGH_CARRY_TO_WORKING: begin
				res_out.working     = {flags_in.carry, mem_in[`RRSB_MSB:`RRSB_ROT_LO]}; // RL3
				res_out.flags.carry = mem_in[`RRSB_LSB]; // RL3
				res_out.wr_working  = 1'b1;
			end
			RRSB_OP_SUB_BORROW,
			RRSB_OP_SUB_BORROW_TO_MEMORY: begin
				res_out.flags.carry        = ~diff[`RRSB_DATA_W]; // RL5
				res_out.flags.half_borrow  = ~nib[`RRSB_NIB_W]; // RL7
				res_out.flags.zero         = (diff[`RRSB_MSB:0] == `RRSB_ZERO_B); // RL7
				res_out.flags.signed_wrap  = (working_in[`RRSB_MSB] != mem_in[`RRSB_MSB])
					&& (diff[`RRSB_MSB] != working_in[`RRSB_MSB]); // RL7
				res_out.flags.second_carry = res_out.flags.signed_wrap
					^ diff[`RRSB_MSB]; // RL7
				res_out.flags.chained_zero = res_out.flags.zero
					& flags_in.chained_zero; // RL7
				if (op_in == RRSB_OP_SUB_BORROW) begin
					res_out.working    = diff[`RRSB_MSB:0]; // RL4
					res_out.wr_working = 1'b1;
				end else begin
					res_out.mem    = diff[`RRSB_MSB:0]; // RL6
					res_out.wr_mem = 1'b1;
				end
			end
			default: begin
				res_out.wr_working = 1'b0;
			end
		endcase
	end

endmodule : rrsb_exec

// File: rrsb_pkg.sv
// Purpose: types shared by the datapath modules
// Assumes: rrsb_cfg.svh supplies widths
// Notes:   flags and results travel as packed structs
`include "rrsb_cfg.svh"

package rrsb_pkg;

	typedef logic [`RRSB_DATA_W-1:0] rrsb_byte_t;
	typedef logic [`RRSB_ADDR_W-1:0] rrsb_addr_t;

	typedef enum logic [2:0] {
		RRSB_OP_RR_TO_WORKING,
		RRSB_OP_RR_THROUGH_CARRY,
		RRSB_OP_RR_THROUGH_CARRY_TO_WORKING,
		RRSB_OP_SUB_BORROW,
		RRSB_OP_SUB_BORROW_TO_MEMORY
	} rrsb_op_t;

	typedef struct packed {
		logic signed_wrap;
		logic zero;
		logic half_borrow;
		logic carry;
		logic second_carry;
		logic chained_zero;
	} rrsb_flags_t;

	typedef struct packed {
		rrsb_byte_t  working;
		rrsb_byte_t  mem;
		rrsb_flags_t flags;
		logic        wr_working;
		logic        wr_mem;
	} rrsb_result_t;

endpackage : rrsb_pkg

// File: tb_top.sv
// Purpose: self-checking bench for rrsb_alu
// Assumes: memory byte held on mem_rdata_in for the whole instruction
// Notes:   random ops from a fixed seed plus a table of corner cases
`timescale 1ns/1ps

module tb_top
	import rrsb_pkg::*;
;
	logic        mclk_in = 0, rst_in = 1, start_in = 0, load_in = 0;
	rrsb_op_t    op_in = RRSB_OP_RR_TO_WORKING;
	rrsb_addr_t  addr_in = '0, mem_addr_out;
	rrsb_byte_t  load_working_in = '0, mem_rdata_in = '0;
	rrsb_byte_t  mem_wdata_out, working_out, w_m;
	rrsb_flags_t load_flags_in = '0, flags_out, f_m;
	logic        mem_rd_out, mem_wr_out, busy_out, done_out;
	int          num_errors = 0, tests_run = 0;
	rrsb_byte_t  cw [5] = '{8'h00, 8'h00, 8'h80, 8'h10, 8'h55};
	rrsb_byte_t  cm [5] = '{8'h00, 8'h81, 8'h01, 8'h01, 8'h55};
	logic        cc [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

	rrsb_alu dut_u (
		.mclk_in(mclk_in), .rst_in(rst_in), .start_in(start_in), .op_in(op_in),
		.addr_in(addr_in), .load_in(load_in), .load_working_in(load_working_in),
		.load_flags_in(load_flags_in), .mem_addr_out(mem_addr_out),
		.mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out),
		.mem_rdata_in(mem_rdata_in), .working_out(working_out), .flags_out(flags_out),
		.busy_out(busy_out), .done_out(done_out)
	);

	initial begin
		forever #25 mclk_in = ~mclk_in;
	end

	// ----------------------------------------------------------------
	// checking and expectations
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	function automatic rrsb_result_t model(rrsb_op_t op, rrsb_byte_t w, rrsb_byte_t m,
		rrsb_flags_t f);
		rrsb_result_t r;
		logic [8:0]   d;
		logic [4:0]   n;
		r = '0;
		r.working = w;
		r.flags = f;
		d = {1'b0, w} - {1'b0, m} - {8'h00, ~f.carry};
		n = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ~f.carry};
		case (op)
			RRSB_OP_RR_TO_WORKING: r.working = {m[0], m[7:1]};
			RRSB_OP_RR_THROUGH_CARRY: begin
				r.mem = {f.carry, m[7:1]};
				r.wr_mem = 1'b1;
				r.flags.carry = m[0];
			end
			RRSB_OP_RR_THROUGH_CARRY_TO_WORKING: begin
				r.working = {f.carry, m[7:1]};
				r.flags.carry = m[0];
			end
			default: begin
				r.flags.carry = ~d[8];
				r.flags.half_borrow = ~n[4];
				r.flags.zero = (d[7:0] == 8'h00);
				r.flags.signed_wrap = (w[7] ^ m[7]) & (d[7] ^ w[7]);
				r.flags.second_carry = r.flags.signed_wrap ^ d[7];
				r.flags.chained_zero = r.flags.zero & f.chained_zero;
				if (op == RRSB_OP_SUB_BORROW) begin
					r.working = d[7:0];
				end else begin
					r.mem = d[7:0];
					r.wr_mem = 1'b1;
				end
			end
		endcase
		return r;
	endfunction : model

	// ----------------------------------------------------------------
	// drivers
	// ----------------------------------------------------------------
	task automatic preload(input rrsb_byte_t w, input rrsb_flags_t f);
		@(posedge mclk_in);
		load_in <= 1'b1;
		load_working_in <= w;
		load_flags_in <= f;
		@(posedge mclk_in);
		load_in <= 1'b0;
		w_m = w;
		f_m = f;
	endtask : preload

	task automatic do_op(input rrsb_op_t op, input rrsb_addr_t a, input rrsb_byte_t m,
		input logic hold);
		rrsb_result_t e;
		int           n;
		int           rd;
		e = model(op, w_m, m, f_m);
		n = 0;
		rd = 0;
		@(posedge mclk_in);
		start_in <= 1'b1;
		op_in <= op;
		addr_in <= a;
		mem_rdata_in <= m;
		@(posedge mclk_in);
		start_in <= hold;
		#1;
		check("busy", 16'(busy_out), 16'd1);
		while (done_out !== 1'b1 && n < 10) begin
			if (mem_rd_out === 1'b1)
				rd++;
			@(posedge mclk_in);
			start_in <= 1'b0;
			#1;
			n++;
		end
		check("cycles", 16'(n), 16'd2);
		check("idle", 16'(busy_out), 16'd0);
		check("reads", 16'(rd), 16'd1);
		check("addr", mem_addr_out, a);
		check("working", 16'(working_out), 16'(e.working));
		check("flags", 16'(flags_out), 16'(e.flags));
		check("wr", 16'(mem_wr_out), 16'(e.wr_mem));
		if (e.wr_mem)
			check("wdata", 16'(mem_wdata_out), 16'(e.mem));
		mem_rdata_in <= ~m;
		w_m = e.working;
		f_m = e.flags;
	endtask : do_op

	task automatic close_out();
		if (num_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int s;
		s = $urandom(32'hdefc);
		repeat (12) @(posedge mclk_in);
		rst_in <= 1'b0;
		@(posedge mclk_in);
		#1;
		check("rst working", 16'(working_out), 16'h0000);
		check("rst flags", 16'(flags_out), 16'h0000);
		for (int o = 0; o < 5; o++) begin
			for (int k = 0; k < 5; k++) begin
				preload(cw[k], rrsb_flags_t'({3'b000, cc[k], 2'b01}));
				do_op(rrsb_op_t'(o), 16'(k), cm[k], 1'b0);
			end
		end
		repeat (200) begin
			if ($urandom_range(0, 1))
				preload(8'($urandom), 6'($urandom));
			do_op(rrsb_op_t'($urandom_range(0, 4)), 16'($urandom), 8'($urandom),
				1'($urandom));
		end
		close_out();
	end

	initial begin
		repeat (20000) @(posedge mclk_in);
		num_errors++;
		close_out();
	end

endmodule : tb_top
